/* File: swn_pkg.sv */
// Shared constants for the serial wiper control block.
// Assumes a 50 MHz system clock; no imports anywhere.
package swn_pkg;
   // System clock period in ns
   localparam int CLK_PERIOD_NS = 20;
   // Wiper and address widths
   localparam int WIPER_W = 8;
   localparam int ADDR_W = 2;
   // Frame bit count: start + address + data
   localparam int FRAME_BITS = 1 + ADDR_W + WIPER_W;
   // Address that selects the single output (first bit 1, second bit 0)
   localparam logic [1:0] OUT_ADDR = 2'h1;
   // Select filter window in ns, and its cycle count (longest time rounds down)
   localparam int SEL_FILT_NS = 60;
   localparam int SEL_FILT_CYC = (SEL_FILT_NS / CLK_PERIOD_NS) < 1 ? 1 : (SEL_FILT_NS / CLK_PERIOD_NS);
   // Erase/write time in ms, typical 4, limit 5
   localparam int STORE_MS = 4;
   localparam int STORE_MAX_MS = 5;
   localparam int STORE_CYC = STORE_MS * 1000000 / CLK_PERIOD_NS;
   // Serial clock edges after the last data bit that programming data survives
   localparam int HOLD_EDGES = 2;
   // Reset value of the wiper before the stored setting is copied in
   localparam logic [7:0] WIPER_RST = 8'h00;
endpackage : swn_pkg

/* File: swn_nv_mem.sv */
// Non-volatile setting cell: one word, written on request, read from a register.
// Assumes the contents persist across reset; default word is a parameter.
`timescale 1ns/100ps
module swn_nv_mem #(
   parameter int W = 8,
   parameter logic [7:0] INIT = 8'h80
) (
   input wire logic clk_i,
   input wire logic wr_i,
   input wire logic [W-1:0] wdata_i,
   output logic [W-1:0] rdata_o
);
   // Stored word, not cleared by reset
   logic [W-1:0] cell_reg = W'(INIT);
   logic [W-1:0] cell_next;
   // Registered read data
   logic [W-1:0] rd_reg = W'(INIT);
   logic [W-1:0] rd_next;

   initial begin
      if (W < 1 || W > 8) $error("swn_nv_mem width unsupported");
   end

   // Write on request, read back the cell
   always_comb begin
      cell_next = wr_i ? wdata_i : cell_reg;
      rd_next = cell_reg;
   end

   // Register the word and read data
   always_ff @(posedge clk_i) begin
      cell_reg <= cell_next;
      rd_reg <= rd_next;
   end

   assign rdata_o = rd_reg;
endmodule // swn_nv_mem

/* File: swn_ctrl.sv */
// Serial wiper control: select filter, frame shifter, wiper load and store sequencer.
// Assumes serial pins and supply-good flag are asynchronous and come from outside.
//
// How it works
// - select low reloads stored value, output floats
// - select filtered against short glitches
// - sample input, advance output on rising clock
// - reset copies stored setting to wiper
// - store request drops ready until done
// - during store ignore input, no output
// - low supply leaves ready high
// - old data shifts out LSB first
// - output driven while select high and not storing
// - new wiper value after last data bit
// - ready for next frame two cycles later
// - every load shifts old contents out
// - temporary value holds while selected
// - unstored data discarded after two edges
// - output address is first one, second zero
// - erase/write ends after STORE_CYCLES - 1 serial clock rises
`timescale 1ns/100ps
module swn_ctrl #(
   parameter int STORE_CYCLES = swn_pkg::STORE_CYC,
   parameter int FILT_CYCLES = swn_pkg::SEL_FILT_CYC,
   parameter logic [7:0] NV_INIT = 8'h80
) (
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire logic device_select_i,
   input wire logic serial_clk_i,
   input wire logic serial_in_i,
   input wire logic store_request_i,
   input wire logic supply_ok_i,
   output logic serial_out_o,
   output logic serial_out_oe_o,
   output logic store_ready_o,
   output logic [7:0] wiper_o
);
   initial begin
      if (STORE_CYCLES < 1 || STORE_CYCLES > 2 ** 24 - 1) $error("store count out of range");
      if (FILT_CYCLES < 1 || FILT_CYCLES > 15) $error("filter count out of range");
   end

   // Two-stage synchronisers for the five pin inputs
   logic [4:0] sync1_reg, sync1_next;
   logic [4:0] sync2_reg, sync2_next;
   // Previous serial clock, for edge detection
   logic sck_d_reg, sck_d_next;
   // Filtered select and its counter
   logic sel_reg, sel_next;
   logic [3:0] filt_cnt_reg, filt_cnt_next;
   // Frame bit counter and input shift register
   logic [3:0] bit_cnt_reg, bit_cnt_next;
   logic [9:0] in_sh_reg, in_sh_next;
   // Wiper, output shifter and serial output
   logic [7:0] wiper_reg, wiper_next;
   logic [7:0] out_sh_reg, out_sh_next;
   logic sout_reg, sout_next;
   // Programming register, its edge age and validity
   logic [7:0] store_request_reg, store_request_next;
   logic store_request_v_reg, store_request_v_next;
   logic [1:0] store_request_age_reg, store_request_age_next;
   // Post-frame gap counter
   logic [1:0] gap_reg, gap_next;
   // Store timer and ready flag
   logic [23:0] st_cnt_reg, st_cnt_next;
   logic rdy_reg, rdy_next;
   logic sreq_d_reg, sreq_d_next;
   // Store request seen after a start bit, waiting for fresh data
   logic arm_reg, arm_next;
   // Reset-time reload pending
   logic boot_reg, boot_next;
   // Non-volatile cell interface
   logic nv_wr;
   logic [7:0] nv_rdata;

   // Frame and store states
   typedef enum logic [2:0] {
      SWN_IDLE = 3'b001,
      SWN_SHIFT = 3'b010,
      SWN_STORE = 3'b100
   } swn_state_e;
   swn_state_e st_reg, st_next;

   // Synchronised pin views
   logic sel_s, sck_s, sdi_s, sreq_s, vok_s;
   logic sck_rise;
   assign sel_s = sync2_reg[0];
   assign sck_s = sync2_reg[1];
   assign sdi_s = sync2_reg[2];
   assign sreq_s = sync2_reg[3];
   assign vok_s = sync2_reg[4];
   assign sck_rise = sck_s & ~sck_d_reg;

   // Non-volatile setting store
   swn_nv_mem #(.W(swn_pkg::WIPER_W), .INIT(NV_INIT)) u_nv (
      .clk_i(clk_i),
      .wr_i(nv_wr),
      .wdata_i(store_request_reg),
      .rdata_o(nv_rdata)
   );

   // Input synchronisers and select glitch filter
   always_comb begin
      sync1_next = {supply_ok_i, store_request_i, serial_in_i, serial_clk_i, device_select_i};
      sync2_next = sync1_reg;
      sck_d_next = sck_s;
      sel_next = sel_reg;
      filt_cnt_next = 4'h0;
      // Select changes only after a steady run of the filter length
      if (sel_s != sel_reg) begin
         filt_cnt_next = filt_cnt_reg + 4'h1;
         if (filt_cnt_reg >= 4'(FILT_CYCLES - 1)) begin
            sel_next = sel_s;
            filt_cnt_next = 4'h0;
         end
      end
   end

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         sync1_reg <= 5'h00;
         sync2_reg <= 5'h00;
         sck_d_reg <= 1'b0;
         sel_reg <= 1'b0;
         filt_cnt_reg <= 4'h0;
      end else begin
         sync1_reg <= sync1_next;
         sync2_reg <= sync2_next;
         sck_d_reg <= sck_d_next;
         sel_reg <= sel_next;
         filt_cnt_reg <= filt_cnt_next;
      end
   end

   // Frame decode, wiper load, programming register and store sequencing
   always_comb begin
      st_next = st_reg;
      bit_cnt_next = bit_cnt_reg;
      in_sh_next = in_sh_reg;
      wiper_next = wiper_reg;
      out_sh_next = out_sh_reg;
      sout_next = sout_reg;
      store_request_next = store_request_reg;
      store_request_v_next = store_request_v_reg;
      store_request_age_next = store_request_age_reg;
      gap_next = gap_reg;
      st_cnt_next = st_cnt_reg;
      rdy_next = rdy_reg;
      sreq_d_next = sreq_s;
      arm_next = arm_reg;
      boot_next = 1'b0;
      nv_wr = 1'b0;
      // Reset-time copy of stored setting, no serial clock needed
      if (boot_reg) begin
         wiper_next = nv_rdata;
      end
      unique case (st_reg)
         SWN_IDLE: begin
            if (!sel_reg) begin
               // Deselected: hold stored value, ignore the pins
               wiper_next = nv_rdata;
               bit_cnt_next = 4'h0;
               gap_next = 2'h0;
               store_request_v_next = 1'b0;
               sout_next = 1'b0;
            end else if (sck_rise) begin
               // Age the programming data, discard after two edges
               if (store_request_v_reg) begin
                  store_request_age_next = store_request_age_reg + 2'h1;
                  if (store_request_age_reg >= 2'(swn_pkg::HOLD_EDGES - 1)) store_request_v_next = 1'b0;
               end
               if (gap_reg != 2'h0) begin
                  gap_next = gap_reg - 2'h1;
               end else if (sdi_s) begin
                  // Start bit seen
                  st_next = SWN_SHIFT;
                  bit_cnt_next = 4'h1;
                  out_sh_next = wiper_reg;
               end
            end
         end
         SWN_SHIFT: begin
            if (!sel_reg) begin
               st_next = SWN_IDLE;
            end else if (sck_rise) begin
               in_sh_next = {sdi_s, in_sh_reg[9:1]};
               bit_cnt_next = bit_cnt_reg + 4'h1;
               // After start and address, old wiper leaves LSB first
               if (bit_cnt_reg >= 4'(1 + swn_pkg::ADDR_W)) begin
                  sout_next = out_sh_reg[0];
                  out_sh_next = {1'b0, out_sh_reg[7:1]};
               end
               if (bit_cnt_reg == 4'(swn_pkg::FRAME_BITS - 1)) begin
                  st_next = SWN_IDLE;
                  gap_next = 2'(swn_pkg::HOLD_EDGES - 1);
                  // Load only for the output's address
                  // Address bits sit at the bottom: first in bit 1, second in bit 2
                  if (in_sh_reg[2:1] == swn_pkg::OUT_ADDR) begin
                     wiper_next = {sdi_s, in_sh_reg[9:3]};
                     store_request_next = {sdi_s, in_sh_reg[9:3]};
                     store_request_v_next = 1'b1;
                     store_request_age_next = 2'h0;
                  end
               end
            end
         end
         SWN_STORE: begin
            // Timer runs on serial clock activity only
            if (sck_rise) st_cnt_next = st_cnt_reg - 24'h1;
            if (st_cnt_reg == 24'h0) begin
               nv_wr = 1'b1;
               rdy_next = 1'b1;
               st_next = SWN_IDLE;
               store_request_v_next = 1'b0;
            end
         end
         default: st_next = SWN_IDLE;
      endcase
      // Request rising mid-frame, or while data is fresh, is remembered
      if (sreq_s && !sreq_d_reg && sel_reg && (st_reg == SWN_SHIFT || store_request_v_reg)) begin
         arm_next = 1'b1;
      end
      // Pending request with fresh data starts erase/write
      if (st_reg != SWN_STORE && arm_next && store_request_v_next) begin
         arm_next = 1'b0;
         if (vok_s) begin
            st_next = SWN_STORE;
            rdy_next = 1'b0;
            st_cnt_next = 24'(STORE_CYCLES - 1);
         end
         // Low supply: ready stays high, nothing recorded
      end else if (st_next == SWN_IDLE && !store_request_v_next) begin
         // Frame ended with no load, or deselected: request lapses
         arm_next = 1'b0;
      end
   end

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         st_reg <= SWN_IDLE;
         bit_cnt_reg <= 4'h0;
         in_sh_reg <= 10'h000;
         wiper_reg <= swn_pkg::WIPER_RST;
         out_sh_reg <= 8'h00;
         sout_reg <= 1'b0;
         store_request_reg <= 8'h00;
         store_request_v_reg <= 1'b0;
         store_request_age_reg <= 2'h0;
         gap_reg <= 2'h0;
         st_cnt_reg <= 24'h000000;
         rdy_reg <= 1'b1;
         sreq_d_reg <= 1'b0;
         boot_reg <= 1'b1;
         arm_reg <= 1'b0;
      end else begin
         st_reg <= st_next;
         bit_cnt_reg <= bit_cnt_next;
         in_sh_reg <= in_sh_next;
         wiper_reg <= wiper_next;
         out_sh_reg <= out_sh_next;
         sout_reg <= sout_next;
         store_request_reg <= store_request_next;
         store_request_v_reg <= store_request_v_next;
         store_request_age_reg <= store_request_age_next;
         gap_reg <= gap_next;
         st_cnt_reg <= st_cnt_next;
         rdy_reg <= rdy_next;
         sreq_d_reg <= sreq_d_next;
         boot_reg <= boot_next;
         arm_reg <= arm_next;
      end
   end

   // Output drive: on while selected and not storing
   assign serial_out_oe_o = sel_reg && (st_reg != SWN_STORE);
   assign serial_out_o = sout_reg;
   assign store_ready_o = rdy_reg;
   assign wiper_o = wiper_reg;

   // Checks
   a_desel_float: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      !sel_reg |-> !serial_out_oe_o) else $error("output driven while deselected");
   a_desel_reload: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      (!sel_reg && st_reg == SWN_IDLE) ##1 !sel_reg |-> wiper_reg == $past(nv_rdata)) else $error("no reload");
   a_sel_drive: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      (sel_reg && st_reg != SWN_STORE) |-> serial_out_oe_o) else $error("output not driven");
   a_store_busy: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      $rose(st_reg == SWN_STORE) |-> !store_ready_o) else $error("ready high in store");
   a_store_quiet: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      st_reg == SWN_STORE |-> !serial_out_oe_o ##1 $stable(wiper_reg)) else $error("activity in store");
   a_low_supply: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      (st_reg != SWN_STORE && !vok_s) |=> st_reg != SWN_STORE) else $error("store at low supply");
   a_filter_span: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      $changed(sel_reg) |-> $past(sel_s) == sel_reg) else $error("select change unfiltered");
   a_sample_edge: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      (st_reg == SWN_SHIFT && !sck_rise && sel_reg) |=> $stable(in_sh_reg)) else $error("shift off edge");
   a_boot_load: assert property (@(posedge clk_i)
      $rose(rst_b_i) |-> ##1 wiper_reg == $past(nv_rdata)) else $error("no boot load");
   c_frame: cover property (@(posedge clk_i) disable iff (!rst_b_i) st_reg == SWN_SHIFT ##[1:400] st_reg == SWN_IDLE);
   c_store: cover property (@(posedge clk_i) disable iff (!rst_b_i) $rose(st_reg == SWN_STORE));
   c_store_done: cover property (@(posedge clk_i) disable iff (!rst_b_i) $fell(st_reg == SWN_STORE));
   c_desel: cover property (@(posedge clk_i) disable iff (!rst_b_i) $fell(sel_reg));
endmodule // swn_ctrl

/* File: swn_host_model.sv */
// Host model: drives select, serial clock, serial data and store request.
// Assumes the system clock paces every pin change; serial clock halves are 5 cycles.
`timescale 1ns/100ps
module swn_host_model (
   input wire logic clk_i,
   input wire logic serial_out_i,
   output logic sel_o,
   output logic sck_o,
   output logic sdi_o,
   output logic store_request_o
);
   // Pins idle low at time zero
   initial begin
      sel_o = 1'b0;
      sck_o = 1'b0;
      sdi_o = 1'b0;
      store_request_o = 1'b0;
   end
   // One serial clock period; output sampled just before the rise
   task automatic tick(input logic b, output logic so);
      sdi_o <= b;
      repeat (4) @(posedge clk_i);
      @(negedge clk_i);
      so = serial_out_i;
      @(posedge clk_i);
      sck_o <= 1'b1;
      repeat (5) @(posedge clk_i);
      sck_o <= 1'b0;
   endtask
   // Free-running edges keep the store timer advancing
   task automatic idle(input int n);
      logic so;
      repeat (n) tick(1'b0, so);
   endtask
   // Select level change, then settle past sync and filter
   task automatic select(input logic v, input int n);
      @(posedge clk_i);
      sel_o <= v;
      repeat (n) @(posedge clk_i);
   endtask
   // Start bit, address, data LSB first, one closing edge
   task automatic frame(input logic [1:0] a, input logic [7:0] d, input logic st, output logic [7:0] old);
      logic so;
      logic b;
      for (int i = 0; i < 12; i++) begin
         b = (i == 0) ? 1'b1 : (i < 3) ? a[i-1] : (i < 11) ? d[i-3] : 1'b0;
         // Raised after start, well before the closing edge
         if (st && i == 5) begin
            store_request_o <= 1'b1;
         end
         tick(b, so);
         // Old contents appear from the fourth edge on
         if (i >= 4) begin
            old[i-4] = so;
         end
      end
      store_request_o <= 1'b0;
      idle(1);  // Two edges before any next start
   endtask
endmodule // swn_host_model

/* File: tb_top.sv */
// Testbench: host model drives the pins; wiper, serial output and ready are checked.
// Assumes a shortened store timer and the default stored word of the design.
`timescale 1ns/100ps
module tb_top;
   localparam int STORE_N = 40;  // Shortened erase/write count
   localparam logic [7:0] NV0 = 8'h80;  // Default stored word
   logic clk_i;
   logic rst_b_i;
   logic supply_ok_i;
   logic sel, sck, sdi, store_request;  // Host pins
   logic serial_out, oe, ready;  // Device pins
   logic so_bus;  // Shared data line, pulled high when released
   assign so_bus = oe ? serial_out : 1'b1;
   logic [7:0] wiper;
   logic [7:0] old, d1, d3;
   logic [31:0] seed;
   int errors;
   int checked;
   // Repeatable xorshift stream
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction
   // Clock, 20 ns period
   initial begin
      clk_i = 1'b0;
      forever #10 clk_i = ~clk_i;
   end
   swn_ctrl #(.STORE_CYCLES(STORE_N), .FILT_CYCLES(3)) swn_ctrl_i (
      .clk_i(clk_i), .rst_b_i(rst_b_i), .device_select_i(sel), .serial_clk_i(sck),
      .serial_in_i(sdi), .store_request_i(store_request), .supply_ok_i(supply_ok_i),
      .serial_out_o(serial_out), .serial_out_oe_o(oe), .store_ready_o(ready), .wiper_o(wiper)
   );
   swn_host_model swn_host_model_i (
      .clk_i(clk_i), .serial_out_i(so_bus), .sel_o(sel), .sck_o(sck), .sdi_o(sdi), .store_request_o(store_request)
   );
   // Compare one value; count and report a difference
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      checked++;
      if (seen !== exp) begin
         errors++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // Counts, verdict, end of run
   task automatic print_verdict();
      $display("Counts: %0d checks, %0d mismatches", checked, errors);
      if (errors == 0 && checked > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   // Bounded wait for ready with the serial clock running
   task automatic wait_ready(input int n);
      int k;
      k = 0;
      while (ready !== 1'b1 && k < n) begin
         swn_host_model_i.idle(1);
         k++;
      end
      if (ready !== 1'b1) begin
         errors++;
         $display("Error at %0t: ready wait ran out", $time);
         print_verdict();
      end
   endtask
   // Main sequence
   initial begin
      errors = 0;
      checked = 0;
      seed = 32'h198a;
      rst_b_i = 1'b0;
      supply_ok_i = 1'b1;
      repeat (3) @(posedge clk_i);
      rst_b_i <= 1'b1;
      repeat (10) @(posedge clk_i);
      check(wiper, NV0);
      check({7'h0, oe}, 8'h00);
      check({7'h0, ready}, 8'h01);
      $display("Test reset done");
      // Temporary loads: random then all ones, back to back
      seed = xs(seed);
      d1 = seed[7:0];
      swn_host_model_i.select(1'b1, 10);
      check({7'h0, oe}, 8'h01);
      swn_host_model_i.frame(swn_pkg::OUT_ADDR, d1, 1'b0, old);
      check(old, NV0);
      check(wiper, d1);
      swn_host_model_i.frame(swn_pkg::OUT_ADDR, 8'hff, 1'b0, old);
      check(old, d1);
      // One-cycle select glitch must not reload
      swn_host_model_i.select(1'b0, 0);
      swn_host_model_i.select(1'b1, 10);
      check(wiper, 8'hff);
      // Poll, then deselect restores the stored word
      swn_host_model_i.frame(swn_pkg::OUT_ADDR, 8'h00, 1'b0, old);
      check(old, 8'hff);
      swn_host_model_i.select(1'b0, 10);
      check(wiper, NV0);
      check({7'h0, oe}, 8'h00);
      // Traffic while deselected
      swn_host_model_i.frame(swn_pkg::OUT_ADDR, 8'h5a, 1'b0, old);
      check(old, 8'hff);
      check(wiper, NV0);
      $display("Test temporary loads done");
      // Every other address loads nothing
      swn_host_model_i.select(1'b1, 10);
      for (int a = 0; a < 4; a++) begin
         if (a != 1) begin
            swn_host_model_i.frame(a[1:0], 8'h33, 1'b0, old);
            check(wiper, NV0);
         end
      end
      $display("Test address done");
      // Store, with a frame sent while busy
      seed = xs(seed);
      d3 = seed[7:0];
      swn_host_model_i.frame(swn_pkg::OUT_ADDR, d3, 1'b1, old);
      check({7'h0, ready}, 8'h00);
      seed = xs(seed);
      swn_host_model_i.frame(swn_pkg::OUT_ADDR, seed[7:0], 1'b0, old);
      check(old, 8'hff);
      check(wiper, d3);
      wait_ready(STORE_N + 20);
      swn_host_model_i.select(1'b0, 10);
      check(wiper, d3);
      $display("Test store done");
      // Low supply: request refused, stored word kept
      supply_ok_i <= 1'b0;
      swn_host_model_i.select(1'b1, 10);
      swn_host_model_i.frame(swn_pkg::OUT_ADDR, ~d3, 1'b1, old);
      check({7'h0, ready}, 8'h01);
      swn_host_model_i.idle(STORE_N + 5);
      swn_host_model_i.select(1'b0, 10);
      check(wiper, d3);
      $display("Test low supply done");
      print_verdict();
   end
endmodule // tb_top
